// ### rtl/pss_status_regs.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
// Function
// - Skew register shows channel A skew in 3:0, channel B in 7:4.
// - Strap one bit 15 shows latched port mirroring strap.
// - Strap one bit 14 shows latched link downshift strap.
// - Larger package only: bit 13 shows clock output off strap.
// - Bit 12 shows reduced gigabit interface off strap.
// - Bit 10 auto crossover off strap; bit 9 forced crossover choice.
// - Bit 8 shows half duplex strap.
// - Bit 7 shows auto negotiation off strap.
// - Speed select: two bits 6:5 larger package, bit 5 smaller package.
// - Management address: 4:0 larger package, 3:0 smaller package.
// - Strap two bit 10 shows fast link drop strap.
// - Smaller package: strap two bits 6:4 transmit clock delay strap.
// - Smaller package: strap two bits 2:0 receive clock delay strap.
// - Sixteen bit received byte count, reset to zero.
// - Count mode zero: byte counter saturates at all ones.
// - Writing bit 0 of error register freezes displayed counters.
// - Writing bit 1 freezes, then clears counters and both overflow flags.
// - Bit 10 flags packet counter overflow until counters cleared.
// - Bit 9 flags byte counter overflow until clear requested.
module pss_status_regs
   import pss_pkg::*;
#(
   parameter bit LARGER_PACKAGE_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [9:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   // Strap pins, sampled once after reset
   input  wire pss_strap_type strap_pins,
   // Receive alignment skew from the datapath
   input  wire logic [3:0]    chan_a_align_cycles,
   input  wire logic [3:0]    chan_b_align_cycles,
   // Checker events from the receive path
   input  wire pss_check_type checker_events,
   // Count mode seen by the checker
   output logic               checker_count_mode
);

   pss_state_type st_ff;
   pss_state_type nxt_st;
   logic [15:0]   strap_one;
   logic [15:0]   strap_two;
   logic [15:0]   skew_word;

   // Saturating or wrapping increment, reports a wrap
   function automatic logic [16:0] bump16(input logic [15:0] v, input logic wrap);
      logic [16:0] r;
      r = {1'b0, v} + 17'h00001;
      if (r[16] && !wrap) begin
         r = {1'b0, 16'hffff};
      end
      return r;
   endfunction

   function automatic logic [8:0] bump8(input logic [7:0] v, input logic wrap);
      logic [8:0] r;
      r = {1'b0, v} + 9'h001;
      if (r[8] && !wrap) begin
         r = {1'b0, 8'hff};
      end
      return r;
   endfunction

   // Strap pins are static at power-up; the two-stage sampler below
   // still guards against a pin that settles late.
   pss_strap_type sync1_ff;
   pss_strap_type sync2_ff;
   logic [1:0]    primed_ff;
   // Primed marks when the second stage holds pin values, not reset zeros
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_ff  <= '0;
         sync2_ff  <= '0;
         primed_ff <= 2'h0;
      end else begin
         sync1_ff  <= strap_pins;
         sync2_ff  <= sync1_ff;
         primed_ff <= {primed_ff[0], 1'b1};
      end
   end

   assign skew_word = {8'h00, chan_b_align_cycles, chan_a_align_cycles};

   always_comb begin
      strap_one = 16'h0000;
      strap_two = 16'h0000;
      strap_one[15] = st_ff.straps.mirror;
      strap_one[14] = st_ff.straps.downshift;
      strap_one[13] = LARGER_PACKAGE_VARIANT ? st_ff.straps.clock_output_off_strap : 1'b0;
      strap_one[12] = st_ff.straps.reduced_gmii_off_strap;
      strap_one[10] = st_ff.straps.auto_crossover_off_strap;
      strap_one[9]  = st_ff.straps.forced_crossover_strap;
      strap_one[8]  = st_ff.straps.half_duplex_strap;
      strap_one[7]  = st_ff.straps.autoneg_off_strap;
      strap_one[5]  = st_ff.straps.speed_select_strap_pair[0];
      strap_one[6]  = LARGER_PACKAGE_VARIANT ? st_ff.straps.speed_select_strap_pair[1] : 1'b0;
      strap_one[3:0] = st_ff.straps.management_address_strap[3:0];
      strap_one[4]   = LARGER_PACKAGE_VARIANT ? st_ff.straps.management_address_strap[4] : 1'b0;
      strap_two[10] = st_ff.straps.fast_link_drop_strap;
      strap_two[6:4] = LARGER_PACKAGE_VARIANT ? 3'h0 : st_ff.straps.tx_delay_strap;
      strap_two[2:0] = LARGER_PACKAGE_VARIANT ? 3'h0 : st_ff.straps.rx_delay_strap;
   end

   always_comb begin
      logic [16:0] nb;
      logic [8:0]  ne;
      logic        take;
      logic        wr;
      logic [7:0]  idx;
      logic        lock_req;
      logic        clear_req;
      nb        = 17'h00000;
      ne        = 9'h000;
      nxt_st    = st_ff;
      idx       = wb_adr_i[9:2];
      take      = wb_cyc_i && wb_stb_i && !st_ff.ack;
      wr        = take && wb_we_i;
      lock_req  = 1'b0;
      clear_req = 1'b0;

      // Straps caught once, three cycles after release
      nxt_st.latched = primed_ff[1];
      if (!st_ff.latched) begin
         nxt_st.straps = sync2_ff;
      end

      if (wr && idx == IDX_ERRST && wb_sel_i[0]) begin
         lock_req  = wb_dat_i[POS_CNT_LOCK];
         clear_req = wb_dat_i[POS_CNT_CLEAR];
      end
      if (wr && idx == IDX_CTRL && wb_sel_i[0]) begin
         nxt_st.checker_count_mode = wb_dat_i[POS_COUNT_MODE];
      end

      if (checker_events.byte_valid) begin
         nb = bump16(st_ff.checker_rx_bytes, st_ff.checker_count_mode);
         nxt_st.checker_rx_bytes = nb[15:0];
         if (nb[16]) begin
            nxt_st.byte_count_overflow = 1'b1;
         end
      end
      if (checker_events.byte_valid && checker_events.byte_error) begin
         ne = bump8(st_ff.checker_error_bytes, st_ff.checker_count_mode);
         nxt_st.checker_error_bytes = ne[7:0];
      end
      if (checker_events.packet_wrap && st_ff.checker_count_mode) begin
         nxt_st.packet_count_overflow = 1'b1;
      end

      if (lock_req || clear_req) begin
         nxt_st.shown_bytes  = st_ff.checker_rx_bytes;
         nxt_st.shown_errors = st_ff.checker_error_bytes;
      end
      // clear after freezing; explicit clear beats a same-cycle event
      if (clear_req) begin
         nxt_st.checker_rx_bytes      = RST_BYTES;
         nxt_st.checker_error_bytes   = RST_ERRS;
         nxt_st.packet_count_overflow = 1'b0;
         nxt_st.byte_count_overflow   = 1'b0;
      end

      // Single-wait-state classic answer
      nxt_st.ack   = take;
      nxt_st.rdata = 32'h0000_0000;
      if (take && !wb_we_i) begin
         unique case (idx)
            IDX_SKEW:   nxt_st.rdata = {16'h0000, skew_word};
            IDX_STRAP1: nxt_st.rdata = {16'h0000, strap_one};
            IDX_STRAP2: nxt_st.rdata = {16'h0000, strap_two};
            IDX_BYTES:  nxt_st.rdata = {16'h0000, st_ff.shown_bytes};
            IDX_ERRST:  nxt_st.rdata = {21'h000000, st_ff.packet_count_overflow,
                                        st_ff.byte_count_overflow, 1'b0, st_ff.shown_errors};
            IDX_CTRL:   nxt_st.rdata = {31'h00000000, st_ff.checker_count_mode};
            default:    nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '{ack: 1'b0, rdata: 32'h0000_0000, latched: 1'b0,
                    straps: pss_strap_type'(22'(RST_STRAPS)), checker_count_mode: 1'b0,
                    checker_rx_bytes: RST_BYTES, checker_error_bytes: RST_ERRS,
                    shown_bytes: RST_BYTES, shown_errors: RST_ERRS,
                    packet_count_overflow: 1'b0, byte_count_overflow: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o           = st_ff.ack;
   assign wb_dat_o           = st_ff.rdata;
   assign checker_count_mode = st_ff.checker_count_mode;

endmodule

// ### rtl/pss_pkg.sv
package pss_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_SKEW   = 8'h55;
   localparam logic [7:0] IDX_STRAP1 = 8'h6e;
   localparam logic [7:0] IDX_STRAP2 = 8'h6f;
   localparam logic [7:0] IDX_BYTES  = 8'h71;
   localparam logic [7:0] IDX_ERRST  = 8'h72;
   localparam logic [7:0] IDX_CTRL   = 8'h16;

   // Field positions
   localparam int POS_CNT_LOCK   = 0;
   localparam int POS_CNT_CLEAR  = 1;
   localparam int POS_BYTE_OVF   = 9;
   localparam int POS_PKT_OVF    = 10;
   localparam int POS_COUNT_MODE = 0;

   // Values after reset
   localparam logic [15:0] RST_BYTES  = 16'h0000;
   localparam logic [7:0]  RST_ERRS   = 8'h00;
   localparam logic [15:0] RST_STRAPS = 16'h0000;

   typedef struct packed {
      logic        mirror;
      logic        downshift;
      logic        clock_output_off_strap;
      logic        reduced_gmii_off_strap;
      logic        auto_crossover_off_strap;
      logic        forced_crossover_strap;
      logic        half_duplex_strap;
      logic        autoneg_off_strap;
      logic [1:0]  speed_select_strap_pair;
      logic [4:0]  management_address_strap;
      logic        fast_link_drop_strap;
      logic [2:0]  tx_delay_strap;
      logic [2:0]  rx_delay_strap;
   } pss_strap_type;

   typedef struct packed {
      logic        byte_valid;
      logic        byte_error;
      logic        packet_wrap;
   } pss_check_type;

   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      logic          latched;
      pss_strap_type straps;
      logic          checker_count_mode;
      logic [15:0]   checker_rx_bytes;
      logic [7:0]    checker_error_bytes;
      logic [15:0]   shown_bytes;
      logic [7:0]    shown_errors;
      logic          packet_count_overflow;
      logic          byte_count_overflow;
   } pss_state_type;

endpackage

// ### sim/pss_status_regs_properties.sv
`timescale 1ns/1ps
module pss_status_regs_properties
   import pss_pkg::*;
#(parameter bit LARGER_PACKAGE_VARIANT = 1'h1) (
   // Clock, reset, bus
   input wire logic          clk,
   input wire logic          reset_n,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_we_i,
   input wire logic [9:0]    wb_adr_i,
   input wire logic [3:0]    wb_sel_i,
   input wire logic [31:0]   wb_dat_i,
   input wire logic [31:0]   wb_dat_o,
   input wire logic          wb_ack_o,
   // Status sources
   input wire pss_strap_type strap_pins,
   input wire logic [3:0]    chan_a_align_cycles,
   input wire logic [3:0]    chan_b_align_cycles,
   input wire pss_check_type checker_events,
   input wire logic          checker_count_mode
);
   wire logic       tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic [7:0] ix = wb_adr_i[9:2];
   wire logic       rd = tk & ~wb_we_i;
   wire logic       wm = tk & wb_we_i & wb_sel_i[0] & (ix == IDX_CTRL);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_ACK_TAKE: assert property (tk |=> wb_ack_o) else $error("no ack after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o || wb_dat_o[31:16] == 16'h0) else $error("upper data bits set");
   AST_SKEW_LIVE: assert property (rd && ix == IDX_SKEW |=>
      wb_dat_o == {24'h0, $past(chan_b_align_cycles), $past(chan_a_align_cycles)}) else $error("skew read wrong");
   AST_STRAP1_RSV: assert property (rd && ix == IDX_STRAP1 |=> !wb_dat_o[11] &&
      (LARGER_PACKAGE_VARIANT || !wb_dat_o[6] && !wb_dat_o[4])) else $error("strap one reserved set");
   AST_STRAP2_RSV: assert property (rd && ix == IDX_STRAP2 |=> wb_dat_o[15:11] == 5'h0 &&
      wb_dat_o[9:7] == 3'h0 && !wb_dat_o[3] && (!LARGER_PACKAGE_VARIANT || wb_dat_o[6:4] == 3'h0 &&
      wb_dat_o[2:0] == 3'h0)) else $error("strap two reserved set");
   AST_ERRST_RSV: assert property (rd && ix == IDX_ERRST |=>
      wb_dat_o[15:11] == 5'h0 && !wb_dat_o[8]) else $error("status reserved set");
   AST_MODE_WRITE: assert property (wm |=> checker_count_mode == $past(wb_dat_i[0])) else $error("mode not written");
   AST_MODE_HOLD: assert property (!wm |=> $stable(checker_count_mode)) else $error("mode changed");
   COV_READ: cover property (rd ##1 wb_ack_o);
   COV_MODE: cover property (wm ##1 checker_count_mode);
   COV_CLEAR: cover property (tk && wb_we_i && ix == IDX_ERRST && wb_dat_i[1]);
endmodule

// ### sim/pss_status_regs_bench.sv
`timescale 1ns/1ps
module pss_status_regs_bench
   import pss_pkg::*;
;
   logic          clk = 1'h0, reset_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [9:0]    adr = 10'h0;
   logic [3:0]    sel = 4'h0, ca, cb;
   logic [31:0]   di = 32'h0, dout, s1, s2;
   logic          ack, mode;
   pss_strap_type sp;
   pss_check_type ev;
   logic [31:0]   q[$];
   int            err_total = 0, num_checks = 0;

   initial forever #50 clk = ~clk;

   pss_status_regs u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .strap_pins(sp),
      .chan_a_align_cycles(ca), .chan_b_align_cycles(cb), .checker_events(ev), .checker_count_mode(mode));

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   // Reads queue their expectation; the monitor compares on ack
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] e);
      int n;
      n = 0;
      if (!w) q.push_back(e);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {i, 2'h0};
      sel <= s;
      di <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (n >= 20) begin
         fail("no ack");
         end_of_test();
      end
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask

   // Checker byte events, packet wrap on each one
   task automatic pulse(input int n, input logic e);
      repeat (n) begin
         ev <= {1'h1, e, 1'h1};
         @(posedge clk);
      end
      ev <= '0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (ack === 1'h1 && we === 1'h0) begin
         num_checks++;
         if (q.size() == 0 || q[0] !== dout) fail("read data mismatch");
         if (q.size() != 0) q.delete(0);
      end
   end

   initial begin
      void'($urandom(80548));
      sp = pss_strap_type'(22'($urandom()));
      ca = 4'($urandom());
      cb = 4'($urandom());
      ev = '0;
      s1 = {16'h0, sp.mirror, sp.downshift, sp.clock_output_off_strap, sp.reduced_gmii_off_strap, 1'h0,
            sp[17:7]};
      s2 = {21'h0, sp.fast_link_drop_strap, 10'h0};
      repeat (3) @(posedge clk);
      reset_n <= 1'h1;
      repeat (6) @(posedge clk);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'h0);
      bus(1'h0, IDX_SKEW, 32'h0, 4'hf, {24'h0, cb, ca});
      bus(1'h0, IDX_STRAP1, 32'h0, 4'hf, s1);
      bus(1'h0, IDX_STRAP2, 32'h0, 4'hf, s2);
      bus(1'h0, 8'h00, 32'h0, 4'hf, 32'h0);
      bus(1'h1, IDX_BYTES, 32'hffff, 4'hf, 32'h0);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'h0);
      bus(1'h1, IDX_CTRL, 32'h1, 4'he, 32'h0);
      num_checks++;
      if (mode !== 1'h0) fail("masked write took effect");
      pulse(65538, 1'h1);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'h0);
      bus(1'h1, IDX_ERRST, 32'h1, 4'hf, 32'h0);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'hffff);
      bus(1'h0, IDX_ERRST, 32'h0, 4'hf, 32'h00ff);
      bus(1'h1, IDX_CTRL, 32'h1, 4'hf, 32'h0);
      pulse(2, 1'h1);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'hffff);
      bus(1'h0, IDX_ERRST, 32'h0, 4'hf, 32'h06ff);
      bus(1'h1, IDX_ERRST, 32'h1, 4'hf, 32'h0);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'h1);
      bus(1'h1, IDX_ERRST, 32'h2, 4'hf, 32'h0);
      bus(1'h0, IDX_ERRST, 32'h0, 4'hf, 32'h0001);
      bus(1'h1, IDX_ERRST, 32'h1, 4'hf, 32'h0);
      bus(1'h0, IDX_BYTES, 32'h0, 4'hf, 32'h0);
      bus(1'h0, IDX_ERRST, 32'h0, 4'hf, 32'h0);
      end_of_test();
   end
endmodule

bind pss_status_regs pss_status_regs_properties #(.LARGER_PACKAGE_VARIANT(LARGER_PACKAGE_VARIANT)) u_props (
   .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .strap_pins(strap_pins), .chan_a_align_cycles(chan_a_align_cycles), .chan_b_align_cycles(chan_b_align_cycles),
   .checker_events(checker_events), .checker_count_mode(checker_count_mode));
